/* File: include/flash_regs_cfg.svh */
`ifndef FLASH_REGS_CFG_SVH
`define FLASH_REGS_CFG_SVH

// ----------------------------------------
// widths
// ----------------------------------------
`define ADDR_W       12
`define DATA_W       16
`define MEM_AW       8
`define MEM_WORDS    256
`define BANK_W       4
`define BANK_LSB     8

// ----------------------------------------
// burst configuration layout and defaults
// ----------------------------------------
`define CFG_RESET    16'hDF48
`define CFG_WMASK    16'hFD87
`define STATUS_RESET      16'h0080
`define STATUS_VIEW_RESET 15'h0040
`define BL_CONT      3'h0
`define BL_WRAP8     3'h2
`define BL_WRAP16    3'h3
`define WORDS8       5'h08
`define WORDS16      5'h10
`define WORDS_ASYNC  5'h01
`define WORDS_CONT   5'h00
`define WS_MIN       4'h2

// ----------------------------------------
// command codes on the write bus
// ----------------------------------------
`define CMD_SET_CONFIG     8'h60
`define CMD_STATUS_READ    8'h70
`define CMD_CLEAR_STATUS   8'h50
`define CMD_ERASE_RESUME   8'h30
`define CMD_PROGRAM_RESUME 8'h31

`endif

/* File: include/flash_regs_pkg.sv */
package flash_regs_pkg;

    // burst_config_reg fields, msb first
    typedef struct packed {
        logic       readAsync;
        logic [3:0] waitStates;
        logic       rdyHigh;
        logic       rsvBit9;
        logic       rdyEarly;
        logic       halfDrive;
        logic [3:0] rsvLow;
        logic [2:0] burstLen;
    } burst_cfg_t;

    // state reported by the program / erase engine
    typedef struct packed {
        logic       busy;
        logic [3:0] bank;
        logic [7:0] progress;
        logic       eraseFail;
        logic       programFail;
        logic       lockFail;
        logic       eraseSuspendEv;
        logic       programSuspendEv;
    } engine_t;

    // word handed from the system domain to the link domain
    typedef struct packed {
        burst_cfg_t cfg;
        logic [15:1] status;
        logic        busy;
        logic [3:0]  bank;
        logic        armTog;
    } link_view_t;

    typedef enum logic [1:0] {
        LINK_IDLE  = 2'b00,
        LINK_WAIT  = 2'b01,
        LINK_BURST = 2'b11,
        LINK_HOLD  = 2'b10
    } link_state_t;

endpackage : flash_regs_pkg

/* File: logic/flash_word_mem.sv */
`timescale 1ns/1ps
`include "flash_regs_cfg.svh"

module flash_word_mem (
    // write side
    input  wire logic                 wrClk,
    input  wire logic                 wrEn,
    input  wire logic [`MEM_AW-1:0]   wrAddr,
    input  wire logic [`DATA_W-1:0]   wrData,
    // read side
    input  wire logic                 rdClk,
    input  wire logic                 rdEn,
    input  wire logic [`MEM_AW-1:0]   rdAddr,
    output logic      [`DATA_W-1:0]   rdData
);

    logic [`DATA_W-1:0] words [0:`MEM_WORDS-1];

    always_ff @(posedge wrClk) begin
        if (wrEn) begin
            words[wrAddr] <= wrData;
        end
    end

    // read data held until the next read, so the last word keeps driving
    always_ff @(posedge rdClk) begin
        if (rdEn) begin
            rdData <= words[rdAddr];
        end
    end

endmodule : flash_word_mem

/* File: logic/flash_config_and_status_regs.sv */
`timescale 1ns/1ps
`include "flash_regs_cfg.svh"

// Behaviour
// - burst length 000 continuous default, 010 wrap 8 words, 011 wrap 16.
// - read-mode bit picks async or burst reads; async after reset.
// - writes always use asynchronous timing regardless of read mode.
// - wait-state field counts link cycles after latch before first word.
// - after wait states each link cycle advances address and presents next word.
// - strobe polarity bit, 1 = active high, reset value 1.
// - strobe timing bit, 1 = one cycle before data, reset value 1.
// - progress reported in one 16-bit status register.
// - burst status read returns the same value every cycle.
// - upper status byte shows the progress code; the code holds the progress captured at the address latch for the whole burst.
// - ready flag 0 while any operation runs; resets to 1, others 0.
// - bits 6..1 meaningful only when ready; bank bit always valid.
// - erase-suspended flag set while suspended, cleared by erase resume.
// - erase-error flag sticky until clear-status or reset.
// - program-error flag sticky until clear-status or reset.
// - program-suspended flag set while suspended, cleared by program resume.
// - sector-lock error sticky until clear-status or reset.
// - busy bank bit reads 0 when operation runs in addressed bank.
// - busy elsewhere reads 1; ready reads 0.
module flash_config_and_status_regs
    import flash_regs_pkg::*;
(
    // system clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   rstn,
    // asynchronous write pins
    input  wire logic                   ceN,
    input  wire logic                   weN,
    input  wire logic [`DATA_W-1:0]     dqIn,
    // burst read link, synchronous to the host clock
    input  wire logic                   linkClk,
    input  wire logic                   address_latch_n,
    input  wire logic                   oeN,
    input  wire logic [`ADDR_W-1:0]     addr,
    output logic      [`DATA_W-1:0]     dqOut,
    output logic                        dqOe,
    output logic                        rdy,
    // program / erase engine
    input  wire flash_regs_pkg::engine_t engine,
    input  wire logic                   engWrEn,
    input  wire logic [`MEM_AW-1:0]     engWrAddr,
    input  wire logic [`DATA_W-1:0]     engWrData,
    output logic                        eraseResume,
    output logic                        programResume
);
    import flash_regs_pkg::*;

    // ----------------------------------------
    // write pin synchronisers
    // ----------------------------------------
    logic               ceS1, ceS2, weS1, weS2, weS3;
    logic [`DATA_W-1:0] dqS1, dqS2;
    logic               writeStrobe;

    always_ff @(posedge sys_clk) begin
        ceS1 <= ceN;
        ceS2 <= ceS1;
        weS1 <= weN;
        weS2 <= weS1;
        weS3 <= weS2;
        dqS1 <= dqIn;
        dqS2 <= dqS1;
    end

    // data is stable well past the write strobe edge, so the late copy is safe
    assign writeStrobe = weS2 && !weS3 && !ceS2;

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic       cfgPending, cfgWrite, clearCmd, statusCmd;
    logic [7:0] cmdCode;

    assign cmdCode   = dqS2[7:0];
    assign cfgWrite  = writeStrobe && cfgPending;
    assign clearCmd  = writeStrobe && !cfgPending && cmdCode == `CMD_CLEAR_STATUS;
    assign statusCmd = writeStrobe && !cfgPending && cmdCode == `CMD_STATUS_READ;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cfgPending    <= 1'b0;
            eraseResume   <= 1'b0;
            programResume <= 1'b0;
        end else begin
            if (writeStrobe) begin
                cfgPending <= !cfgPending && cmdCode == `CMD_SET_CONFIG;
            end
            eraseResume   <= writeStrobe && !cfgPending && cmdCode == `CMD_ERASE_RESUME;
            programResume <= writeStrobe && !cfgPending && cmdCode == `CMD_PROGRAM_RESUME;
        end
    end

    // ----------------------------------------
    // burst configuration
    // ----------------------------------------
    burst_cfg_t cfg;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            cfg <= `CFG_RESET;
        end else if (cfgWrite) begin
            cfg <= (dqS2 & `CFG_WMASK) | (`CFG_RESET & ~`CFG_WMASK);
        end
    end

    // ----------------------------------------
    // sticky status flags
    // ----------------------------------------
    logic eraseSusp, eraseErr, progErr, progSusp, lockErr, armTog;
    logic [15:1] statusLive;

    // an engine event in the clearing cycle still lands
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            eraseErr <= 1'b0;
            progErr  <= 1'b0;
            lockErr  <= 1'b0;
        end else begin
            eraseErr <= engine.eraseFail || (eraseErr && !clearCmd);
            progErr  <= engine.programFail || (progErr && !clearCmd);
            lockErr  <= engine.lockFail || (lockErr && !clearCmd);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            eraseSusp <= 1'b0;
            progSusp  <= 1'b0;
        end else begin
            eraseSusp <= engine.eraseSuspendEv || (eraseSusp && !eraseResume);
            progSusp  <= engine.programSuspendEv || (progSusp && !programResume);
        end
    end

    // each status-read command flips the arm; an odd count since the last read arms exactly one later read
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            armTog <= 1'b0;
        end else if (statusCmd) begin
            armTog <= !armTog;
        end
    end

    assign statusLive = {engine.progress, !engine.busy, eraseSusp, eraseErr,
                         progErr, 1'b0, progSusp, lockErr};

    // ----------------------------------------
    // crossing to the link domain (toggle handshake)
    // ----------------------------------------
    link_view_t liveView, xferView, view;
    logic       reqTog, ackS1, ackS2;
    logic       reqS1, reqS2, seenTog;

    assign liveView = '{cfg: cfg, status: statusLive, busy: engine.busy,
                        bank: engine.bank, armTog: armTog};

    // word only changes while the previous one has been acknowledged
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            xferView <= '{cfg: `CFG_RESET, status: `STATUS_VIEW_RESET, busy: 1'b0,
                          bank: 4'h0, armTog: 1'b0};
            reqTog   <= 1'b0;
        end else if (reqTog == ackS2 && xferView != liveView) begin
            xferView <= liveView;
            reqTog   <= !reqTog;
        end
    end

    always_ff @(posedge sys_clk) begin
        ackS1 <= seenTog;
        ackS2 <= ackS1;
    end

    // ----------------------------------------
    // link domain reset and capture
    // ----------------------------------------
    logic linkRstS1, linkRstn;

    always_ff @(posedge linkClk) begin
        linkRstS1 <= rstn;
        linkRstn  <= linkRstS1;
    end

    always_ff @(posedge linkClk) begin
        if (!linkRstn) begin
            reqS1   <= 1'b0;
            reqS2   <= 1'b0;
            seenTog <= 1'b0;
            view    <= '{cfg: `CFG_RESET, status: `STATUS_VIEW_RESET, busy: 1'b0,
                         bank: 4'h0, armTog: 1'b0};
        end else begin
            reqS1 <= reqTog;
            reqS2 <= reqS1;
            if (reqS2 != seenTog) begin
                seenTog <= reqS2;
                view    <= xferView;
            end
        end
    end

    // ----------------------------------------
    // burst read engine
    // ----------------------------------------
    link_state_t        state;
    logic               latchNow, issue, done, statusRd, usedTog, dataValid;
    logic [3:0]         wsEff, waitCnt, wsHeld;
    logic [4:0]         lenEff, wordCnt;
    logic [`ADDR_W-1:0] curAddr, nextAddr;
    logic [`DATA_W-1:0] statusWord, memData;
    logic               rdyActive;

    assign latchNow = !ceN && !address_latch_n;

    // reserved wait codes fall back to the shortest legal wait
    assign wsEff = view.cfg.readAsync || view.cfg.waitStates < `WS_MIN
                   ? `WS_MIN : view.cfg.waitStates;

    always_comb begin
        if (view.cfg.readAsync) begin
            lenEff = `WORDS_ASYNC;
        end else begin
            case (view.cfg.burstLen)
                `BL_WRAP8:  lenEff = `WORDS8;
                `BL_WRAP16: lenEff = `WORDS16;
                default:    lenEff = `WORDS_CONT;
            endcase
        end
    end

    always_comb begin
        case (view.cfg.burstLen)
            `BL_WRAP8:  nextAddr = {curAddr[`ADDR_W-1:3], curAddr[2:0] + 3'h1};
            `BL_WRAP16: nextAddr = {curAddr[`ADDR_W-1:4], curAddr[3:0] + 4'h1};
            default:    nextAddr = curAddr + `ADDR_W'(1);
        endcase
    end

    assign done  = lenEff != `WORDS_CONT && wordCnt == lenEff;
    assign issue = (state == LINK_WAIT && waitCnt == 4'h1)
                   || (state == LINK_BURST && !done);

    always_ff @(posedge linkClk) begin
        if (!linkRstn || ceN) begin
            state <= LINK_IDLE;
        end else if (latchNow) begin
            state <= LINK_WAIT;
        end else begin
            case (state)
                LINK_WAIT:  state <= waitCnt == 4'h1 ? LINK_BURST : LINK_WAIT;
                LINK_BURST: state <= done ? LINK_HOLD : LINK_BURST;
                LINK_HOLD:  state <= LINK_HOLD;
                default:    state <= LINK_IDLE;
            endcase
        end
    end

    always_ff @(posedge linkClk) begin
        if (!linkRstn) begin
            waitCnt <= 4'h0;
            wsHeld  <= `WS_MIN;
            wordCnt <= 5'h00;
            curAddr <= '0;
        end else if (latchNow) begin
            waitCnt <= wsEff - 4'h1;
            wsHeld  <= wsEff;
            wordCnt <= 5'h00;
            curAddr <= addr;
        end else begin
            if (state == LINK_WAIT) begin
                waitCnt <= waitCnt - 4'h1;
            end
            if (issue) begin
                wordCnt <= wordCnt + 5'h01;
                curAddr <= nextAddr;
            end
        end
    end

    // status is frozen at the address latch and replayed for the whole burst
    always_ff @(posedge linkClk) begin
        if (!linkRstn) begin
            statusRd   <= 1'b0;
            usedTog    <= 1'b0;
            statusWord <= `STATUS_RESET;
        end else if (latchNow) begin
            statusRd   <= view.armTog != usedTog;
            usedTog    <= view.armTog;
            statusWord <= {view.status,
                           view.busy && view.bank != addr[`BANK_LSB +: `BANK_W]};
        end
    end

    always_ff @(posedge linkClk) begin
        if (!linkRstn || ceN || latchNow) begin
            dataValid <= 1'b0;
        end else if (issue) begin
            dataValid <= 1'b1;
        end
    end

    flash_word_mem arrayWords (
        .wrClk  (sys_clk),
        .wrEn   (engWrEn),
        .wrAddr (engWrAddr),
        .wrData (engWrData),
        .rdClk  (linkClk),
        .rdEn   (issue && !statusRd),
        .rdAddr (curAddr[`MEM_AW-1:0]),
        .rdData (memData)
    );

    assign dqOut     = statusRd ? statusWord : memData;
    assign dqOe      = !ceN && !oeN && dataValid;
    assign rdyActive = view.cfg.rdyEarly ? issue : dataValid && state != LINK_HOLD;
    assign rdy       = view.cfg.rdyHigh ? rdyActive : !rdyActive;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic [7:0] sinceLatch;

    always_ff @(posedge linkClk) begin
        if (!linkRstn || latchNow) begin
            sinceLatch <= 8'h00;
        end else if (sinceLatch != 8'hFF) begin
            sinceLatch <= sinceLatch + 8'h01;
        end
    end

    a_async_after_reset: assert property (@(posedge sys_clk) !rstn |=> cfg.readAsync)
        else $error("read mode not async after reset");
    a_rdy_pol_reset: assert property (@(posedge sys_clk) !rstn |=> cfg.rdyHigh)
        else $error("strobe polarity not high after reset");
    a_rdy_time_reset: assert property (@(posedge sys_clk) !rstn |=> cfg.rdyEarly)
        else $error("strobe timing not early after reset");
    a_reserved_kept: assert property (@(posedge sys_clk) disable iff (!rstn)
        cfgWrite |=> (cfg & ~`CFG_WMASK) == (`CFG_RESET & ~`CFG_WMASK))
        else $error("reserved config bits changed");
    a_erase_err_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
        engine.eraseFail |=> eraseErr ##1 (eraseErr || $past(clearCmd)))
        else $error("erase error lost");
    a_lock_err_sticky: assert property (@(posedge sys_clk) disable iff (!rstn)
        lockErr && !clearCmd |=> lockErr)
        else $error("lock error dropped without clear");
    a_prog_susp_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
        programResume && !engine.programSuspendEv |=> !progSusp)
        else $error("program suspended not cleared by resume");
    a_bank_bit_ready: assert property (@(posedge linkClk) disable iff (!linkRstn)
        statusRd && dataValid && dqOut[7] |-> !dqOut[0])
        else $error("ready with bank bit set");
    a_first_word_wait: assert property (@(posedge linkClk) disable iff (!linkRstn)
        $rose(dataValid) |-> sinceLatch + 8'h01 == {4'h0, wsHeld})
        else $error("first word after wrong wait count");
    a_status_steady: assert property (@(posedge linkClk) disable iff (!linkRstn)
        statusRd && dataValid && !latchNow |=> !dataValid || $stable(dqOut))
        else $error("status changed during burst");
    a_wrap8_length: assert property (@(posedge linkClk) disable iff (!linkRstn)
        state == LINK_HOLD && !view.cfg.readAsync && view.cfg.burstLen == `BL_WRAP8
        |-> wordCnt == `WORDS8)
        else $error("wrap-8 burst length wrong");

    c_status_burst: cover property (@(posedge linkClk) disable iff (!linkRstn)
        statusRd && dataValid [*3]);
    c_wrap8_done: cover property (@(posedge linkClk) disable iff (!linkRstn)
        state == LINK_HOLD && view.cfg.burstLen == `BL_WRAP8);
    c_config_write: cover property (@(posedge sys_clk) disable iff (!rstn) cfgWrite);
    c_clear_vs_fail: cover property (@(posedge sys_clk) disable iff (!rstn)
        clearCmd && engine.eraseFail);

endmodule : flash_config_and_status_regs

/* File: tb/flash_host_model.sv */
`timescale 1ns/1ps
`include "flash_regs_cfg.svh"

module flash_host_model (
    // clocks
    input  wire logic                 sys_clk,
    input  wire logic                 linkClk,
    // write pins
    output logic                      ceN,
    output logic                      weN,
    output logic      [`DATA_W-1:0]   dqIn,
    // burst read pins
    output logic                      address_latch_n,
    output logic                      oeN,
    output logic      [`ADDR_W-1:0]   addr,
    input  wire logic [`DATA_W-1:0]   dqOut,
    input  wire logic                 dqOe,
    input  wire logic                 rdy
);
    logic [15:0] got [0:31];
    logic        rdyAt [0:47];
    int          firstAt;

    initial begin
        ceN = 1'b1;
        weN = 1'b1;
        dqIn = 16'h0000;
        address_latch_n = 1'b1;
        oeN = 1'b1;
        addr = 12'h000;
    end

    // ----------------------------------------
    // write bus
    // ----------------------------------------
    // plain strobes, never tied to linkClk, whatever the read mode
    task automatic write_word(input logic [15:0] data);
        @(posedge sys_clk);
        #1;
        ceN = 1'b0;
        dqIn = data;
        weN = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        weN = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1;
        ceN = 1'b1;
        dqIn = ~data;
    endtask : write_word

    // ----------------------------------------
    // burst read
    // ----------------------------------------
    // bounded at 48 edges so a silent device cannot hang the host
    task automatic burst(input logic [11:0] a, input int n);
        int k;
        int cnt;
        @(posedge linkClk);
        #1;
        ceN = 1'b0;
        oeN = 1'b0;
        address_latch_n = 1'b0;
        addr = a;
        @(posedge linkClk);
        #1;
        address_latch_n = 1'b1;
        addr = ~a;
        // k numbers the cycle being sampled, the latch cycle being 0
        rdyAt[1] = rdy;
        firstAt = -1;
        cnt = 0;
        k = 2;
        while (cnt < n && k < 48) begin
            @(posedge linkClk);
            #1;
            rdyAt[k] = rdy;
            if (dqOe === 1'b1) begin
                if (firstAt < 0) firstAt = k;
                got[cnt] = dqOut;
                cnt++;
            end
            k++;
        end
        ceN = 1'b1;
        oeN = 1'b1;
    endtask : burst
endmodule : flash_host_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
`include "flash_regs_cfg.svh"

module tb;
    import flash_regs_pkg::*;
    localparam int LIMIT = 40000;
    logic        sys_clk, rstn, linkClk, ceN, weN, address_latch_n, oeN, dqOe, rdy;
    logic [15:0] dqIn, dqOut, engWrData;
    logic [11:0] addr;
    logic [7:0]  engWrAddr;
    logic        engWrEn, eraseResume, programResume;
    engine_t     engine;
    int          n_errors, checked, cycles, nEraseRes, nProgRes;
    logic [2:0]  rowBl [3] = '{3'h2, 3'h3, 3'h0};
    int          rowN [3] = '{8, 16, 10};
    logic [11:0] rowA [3] = '{12'h00D, 12'h01B, 12'h0FC};
    logic [3:0]  rowWs [3] = '{4'h4, 4'h5, 4'h2};
    logic        rowHi [3] = '{1'b1, 1'b1, 1'b0};
    logic        rowEarly [3] = '{1'b0, 1'b1, 1'b1};

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // link clock runs free: the design's crossing needs it during reset too
    initial begin
        linkClk = 1'b0;
        #37;
        forever #62.5 linkClk = ~linkClk;
    end

    flash_config_and_status_regs i_dut (.sys_clk(sys_clk), .rstn(rstn), .ceN(ceN), .weN(weN),
        .dqIn(dqIn), .linkClk(linkClk), .address_latch_n(address_latch_n), .oeN(oeN),
        .addr(addr), .dqOut(dqOut), .dqOe(dqOe), .rdy(rdy), .engine(engine),
        .engWrEn(engWrEn), .engWrAddr(engWrAddr), .engWrData(engWrData),
        .eraseResume(eraseResume), .programResume(programResume));

    flash_host_model i_host (.sys_clk(sys_clk), .linkClk(linkClk), .ceN(ceN), .weN(weN),
        .dqIn(dqIn), .address_latch_n(address_latch_n), .oeN(oeN), .addr(addr),
        .dqOut(dqOut), .dqOe(dqOe), .rdy(rdy));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [15:0] memv(input logic [7:0] a);
        return {a ^ 8'h5A, a};
    endfunction : memv

    function automatic logic [15:0] cfgw(input logic [3:0] ws, input logic hi,
                                         input logic early, input logic [2:0] bl,
                                         input logic flipRsv);
        return flipRsv ? {1'b0, ws, hi, 1'b0, early, 1'b0, 4'h6, bl}
                       : {1'b0, ws, hi, 1'b1, early, 1'b0, 4'h9, bl};
    endfunction : cfgw

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic pulse(input logic [4:0] ev);
        @(posedge sys_clk);
        #1;
        engine[4:0] = ev;
        @(posedge sys_clk);
        #1;
        engine[4:0] = 5'h00;
    endtask : pulse

    // fresh command before every status read; all words of the burst compared
    task automatic status_read(input logic [11:0] a, input int n, input logic [15:0] exp);
        i_host.write_word({8'h00, `CMD_STATUS_READ});
        repeat (8) @(posedge linkClk);
        i_host.burst(a, n);
        for (int i = 0; i < n; i++) check(i_host.got[i], exp);
    endtask : status_read

    task automatic set_cfg(input logic [15:0] w);
        i_host.write_word({8'h00, `CMD_SET_CONFIG});
        i_host.write_word(w);
        repeat (8) @(posedge linkClk);
    endtask : set_cfg

    always @(posedge sys_clk) begin
        if (eraseResume === 1'b1) nEraseRes++;
        if (programResume === 1'b1) nProgRes++;
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            end_sim();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [11:0] ea;
        n_errors = 0;
        checked = 0;
        cycles = 0;
        nEraseRes = 0;
        nProgRes = 0;
        engine = '0;
        engWrEn = 1'b0;
        engWrAddr = 8'h00;
        engWrData = 16'h0000;
        rstn = 1'b0;
        // held over five link cycles so both domains see it
        repeat (5) @(posedge linkClk);
        @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        engine.progress = 8'h5A;
        for (int a = 0; a < 256; a++) begin
            @(posedge sys_clk);
            #1;
            engWrEn = 1'b1;
            engWrAddr = a[7:0];
            engWrData = memv(a[7:0]);
        end
        @(posedge sys_clk);
        #1;
        engWrEn = 1'b0;
        // defaults: one async word at latency 2, strobe high one cycle early
        status_read(12'h000, 1, 16'h5A80);
        check(i_host.firstAt, 2);
        check(i_host.rdyAt[1], 1);
        i_host.burst(12'h012, 1);
        check(i_host.got[0], memv(8'h12));
        for (int r = 0; r < 3; r++) begin
            set_cfg(cfgw(rowWs[r], rowHi[r], rowEarly[r], rowBl[r], r == 0));
            i_host.burst(rowA[r], rowN[r]);
            check(i_host.firstAt, rowWs[r]);
            if (rowEarly[r])
                check(i_host.rdyAt[rowWs[r]-1], rowHi[r]);
            else begin
                check(i_host.rdyAt[rowWs[r]-1], !rowHi[r]);
                check(i_host.rdyAt[rowWs[r]], rowHi[r]);
            end
            for (int i = 0; i < rowN[r]; i++) begin
                case (rowBl[r])
                    3'h2: ea = {rowA[r][11:3], rowA[r][2:0] + i[2:0]};
                    3'h3: ea = {rowA[r][11:4], rowA[r][3:0] + i[3:0]};
                    default: ea = rowA[r] + i[11:0];
                endcase
                check(i_host.got[i], memv(ea[7:0]));
            end
        end
        // flags set together, read as a burst in sync mode after a four-cycle wait
        pulse(5'h1F);
        repeat (4) @(posedge sys_clk);
        status_read(12'h000, 4, 16'h5AF6);
        i_host.write_word({8'h00, `CMD_ERASE_RESUME});
        status_read(12'h000, 1, 16'h5AB6);
        i_host.write_word({8'h00, `CMD_PROGRAM_RESUME});
        status_read(12'h000, 1, 16'h5AB2);
        i_host.write_word({8'h00, `CMD_CLEAR_STATUS});
        status_read(12'h000, 1, 16'h5A80);
        check(nEraseRes, 1);
        check(nProgRes, 1);
        @(posedge sys_clk);
        #1;
        engine.busy = 1'b1;
        engine.bank = 4'h3;
        status_read(12'h3F0, 1, 16'h5A00);
        status_read(12'h520, 1, 16'h5A01);
        @(posedge sys_clk);
        #1;
        engine.busy = 1'b0;
        status_read(12'h520, 1, 16'h5A80);
        end_sim();
    end
endmodule : tb
